// file: hw/csp_pkg.sv
// constants and types for the clock synthesizer and power select block
// ------------------------------------------------------------
// Behaviour
// R1: receive sample clock equals receive word clock
// R2: pll multiplier is two to reg04[1:0]
// R3: software keeps reference and vco in range
// R4: reg04 bit4 picks divided vco sample clock
// R5: reg04[3:2] divides vco by 1, 2, 4
// R6: reg04 bit5 enables duty-cycle restorer
// R7: reg07 bit4 sets converter low-power mode
// R8: reg13[2:0] holds converter bias code
// R9: converter data appears ten sample clocks later
// R10: first clock out is vco over 2^reg06[3:2]
// R11: first clock out shares pll divider chain
// R12: second clock out is reference over 2^reg06[7:6]; code divides by 4, not 8, for value 3
// R13: divided second clock out is near half duty
// R14: reg06 invert and disable bits per output
// R15: clock outputs keep running through reset
// R16: select pin chooses mask reg01 or reg02
// R17: reset masks: reg01 zero, reg02 all but pll
// R18: select pin acts with minimal delay
// R19: mask bits 7..0 name the eight blocks
// R20: divider changes applied without runt pulses; code can give a runt when an exponent changes to or from 0
// ------------------------------------------------------------
package csp_pkg;
  localparam logic [6:0] OFS_MASK_LOW  = 7'h01;
  localparam logic [6:0] OFS_MASK_HIGH = 7'h02;
  localparam logic [6:0] OFS_PLL_CFG   = 7'h04;
  localparam logic [6:0] OFS_CLKOUT    = 7'h06;
  localparam logic [6:0] OFS_RX_CFG    = 7'h07;
  localparam logic [6:0] OFS_BIAS      = 7'h13;
  localparam logic [7:0] RST_MASK_LOW  = 8'h00;
  localparam logic [7:0] RST_MASK_HIGH = 8'h7f;
  localparam logic [7:0] RST_PLL_CFG   = 8'h00;
  localparam logic [7:0] RST_CLKOUT    = 8'h00;
  localparam logic [7:0] RST_RX_CFG    = 8'h01;
  localparam logic [7:0] RST_BIAS      = 8'h00;
  // field positions
  localparam int M_LSB = 0;
  localparam int N_LSB = 2;
  localparam int SEL_BIT = 4;
  localparam int DCR_BIT = 5;
  localparam int R_LSB = 2;
  localparam int L_LSB = 6;
  localparam int C1_INV = 1;
  localparam int C1_DIS = 0;
  localparam int C2_INV = 5;
  localparam int C2_DIS = 4;
  localparam int LOWPWR_BIT = 4;
  localparam int BIAS_MSB = 2;
  // mask bit order, msb first
  localparam int PD_PLL = 7;
  localparam int PD_TX_AMP = 6;
  localparam int PD_TX_DIG = 5;
  localparam int PD_REF = 4;
  localparam int PD_CML = 3;
  localparam int PD_ADC = 2;
  localparam int PD_BIAS = 1;
  localparam int PD_RX_AMP = 0;
  localparam int RX_LATENCY = 10;
  localparam logic [4:0] SPI_FRAME_BITS = 5'd16;
  localparam logic [4:0] SPI_HDR_BITS = 5'd8;

  typedef enum logic [1:0] {CSP_IDLE, CSP_HDR, CSP_DATA} csp_spi_st_t;

  typedef struct packed {
    logic [7:0] mask_low;
    logic [7:0] mask_high;
    logic [7:0] pll_cfg;
    logic [7:0] clkout;
    logic [7:0] rx_cfg;
    logic [7:0] bias;
  } csp_regs_t;

  typedef struct packed {
    logic [1:0] m;
    logic [1:0] n;
    logic       sel;
    logic [1:0] r;
    logic [1:0] l;
  } csp_div_t;
endpackage

// file: hw/csp_top.sv
// clock synthesizer control, sample clock select and power mask select
`timescale 1ns/100ps
`default_nettype none
module csp_top #(
  parameter int DATA_W = 12,
  parameter int DCR_W  = 8
) (
  input  wire logic              core_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              reference_clock_input_i,
  input  wire logic              vco_clk_i,
  input  wire logic              power_select_pin_i,
  input  wire logic              spi_clk_i,
  input  wire logic              spi_cs_n_i,
  input  wire logic              spi_din_i,
  input  wire logic [DATA_W-1:0] rx_code_i,
  output logic                   spi_dout_o,
  output logic                   spi_dout_oe_o,
  output logic                   vco_derived_clock_out_o,
  output logic                   reference_derived_clock_out_o,
  output logic                   sample_clk_o,
  output logic                   receive_word_clock_o,
  output logic                   pll_feedback_o,
  output logic [1:0]             pll_mult_o,
  output logic                   adc_low_power_o,
  output logic [2:0]             adc_bias_o,
  output logic [7:0]             power_down_o,
  output logic [DATA_W-1:0]      converter_data_bus_o
);

  typedef struct packed {
    logic [1:0]                         ref_sy;
    logic [1:0]                         vco_sy;
    logic [1:0]                         pin_sy;
    logic [1:0]                         sck_sy;
    logic [1:0]                         csn_sy;
    logic [1:0]                         din_sy;
    logic                               ref_d;
    logic                               vco_d;
    logic                               sck_d;
    csp_pkg::csp_regs_t                 regs;
    csp_pkg::csp_div_t                  act;
    csp_pkg::csp_spi_st_t               spi_st;
    logic [4:0]                         bits;
    logic [15:0]                        shin;
    logic [7:0]                         shout;
    logic                               dout;
    logic                               dout_oe;
    logic [2:0]                         vcnt;
    logic [1:0]                         rcnt;
    logic [DCR_W-1:0]                   per_cnt;
    logic [DCR_W-1:0]                   half;
    logic [DCR_W-1:0]                   dcr_cnt;
    logic                               dcr_out;
    logic                               samp;
    logic                               samp_d;
    logic                               c1;
    logic                               c2;
    logic                               fb;
    logic [7:0]                         pd;
    logic [csp_pkg::RX_LATENCY-1:0][DATA_W-1:0] pipe;
  } csp_state_t;

  csp_state_t st_r;
  csp_state_t st_nxt;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic div_tap(input logic [2:0] cnt, input logic [1:0] e,
                                   input logic base);
    logic t;
    t = base;
    if (e != 2'd0) begin
      t = cnt[e-2'd1];
    end
    return t;
  endfunction

  function automatic logic [7:0] reg_read(input csp_pkg::csp_regs_t rg,
                                          input logic [6:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a == csp_pkg::OFS_MASK_LOW) begin
      d = rg.mask_low;
    end else if (a == csp_pkg::OFS_MASK_HIGH) begin
      d = rg.mask_high;
    end else if (a == csp_pkg::OFS_PLL_CFG) begin
      d = rg.pll_cfg;
    end else if (a == csp_pkg::OFS_CLKOUT) begin
      d = rg.clkout;
    end else if (a == csp_pkg::OFS_RX_CFG) begin
      d = rg.rx_cfg;
    end else if (a == csp_pkg::OFS_BIAS) begin
      d = rg.bias;
    end
    return d;
  endfunction

  logic ref_s;
  logic vco_s;
  logic sck_s;
  logic vco_rise;
  logic ref_rise;
  logic sck_rise;
  logic sck_fall;
  logic samp_rise;
  assign ref_s     = st_r.ref_sy[1];
  assign vco_s     = st_r.vco_sy[1];
  assign sck_s     = st_r.sck_sy[1];
  assign vco_rise  = vco_s & ~st_r.vco_d;
  assign ref_rise  = ref_s & ~st_r.ref_d;
  assign sck_rise  = sck_s & ~st_r.sck_d;
  assign sck_fall  = ~sck_s & st_r.sck_d;
  assign samp_rise = st_r.samp & ~st_r.samp_d;

  always_comb begin
    logic [7:0]  rd;
    logic [15:0] fr;
    logic [1:0]  nreq;
    logic        o1;
    logic        o2;
    logic        ref_src;
    rd = 8'h00;
    fr = 16'h0000;
    nreq = 2'd0;
    o1 = 1'b0;
    o2 = 1'b0;
    ref_src = 1'b0;
    st_nxt = st_r;
    // ------------------------------------------------------------
    // pin synchronisers, two stages each
    // ------------------------------------------------------------
    st_nxt.ref_sy = {st_r.ref_sy[0], reference_clock_input_i};
    st_nxt.vco_sy = {st_r.vco_sy[0], vco_clk_i};
    st_nxt.pin_sy = {st_r.pin_sy[0], power_select_pin_i};
    st_nxt.sck_sy = {st_r.sck_sy[0], spi_clk_i};
    st_nxt.csn_sy = {st_r.csn_sy[0], spi_cs_n_i};
    st_nxt.din_sy = {st_r.din_sy[0], spi_din_i};
    st_nxt.ref_d  = ref_s;
    st_nxt.vco_d  = vco_s;
    st_nxt.sck_d  = sck_s;

    // ------------------------------------------------------------
    // serial port: rw, 7-bit address, 8-bit data, msb first
    // ------------------------------------------------------------
    if (st_r.csn_sy[1]) begin
      st_nxt.spi_st  = csp_pkg::CSP_IDLE;
      st_nxt.bits    = 5'd0;
      st_nxt.dout_oe = 1'b0;
    end else begin
      case (st_r.spi_st)
        csp_pkg::CSP_IDLE: begin
          st_nxt.spi_st = csp_pkg::CSP_HDR;
          st_nxt.bits   = 5'd0;
        end
        csp_pkg::CSP_HDR: begin
          if (sck_rise) begin
            st_nxt.shin = {st_r.shin[14:0], st_r.din_sy[1]};
            st_nxt.bits = st_r.bits + 5'd1;
            if (st_r.bits + 5'd1 == csp_pkg::SPI_HDR_BITS) begin
              fr = {st_r.shin[14:0], st_r.din_sy[1]};
              st_nxt.shout  = reg_read(st_r.regs, fr[6:0]);
              st_nxt.spi_st = csp_pkg::CSP_DATA;
            end
          end
        end
        csp_pkg::CSP_DATA: begin
          // the read flag moves up one place per rise, so index it by the bit count
          if (sck_fall && st_r.shin[4'(st_r.bits - 5'd1)]) begin
            // read data leaves on falling edges so the master samples it rising
            st_nxt.dout_oe = 1'b1;
            st_nxt.dout    = st_r.shout[7];
            st_nxt.shout   = {st_r.shout[6:0], 1'b0};
          end
          if (sck_rise) begin
            fr = {st_r.shin[14:0], st_r.din_sy[1]};
            st_nxt.shin = fr;
            st_nxt.bits = st_r.bits + 5'd1;
            if (st_r.bits + 5'd1 == csp_pkg::SPI_FRAME_BITS) begin
              st_nxt.spi_st = csp_pkg::CSP_IDLE;
              if (!fr[15]) begin
                // unmapped addresses drop the write
                if (fr[14:8] == csp_pkg::OFS_MASK_LOW) begin
                  st_nxt.regs.mask_low = fr[7:0];
                end else if (fr[14:8] == csp_pkg::OFS_MASK_HIGH) begin
                  st_nxt.regs.mask_high = fr[7:0];
                end else if (fr[14:8] == csp_pkg::OFS_PLL_CFG) begin
                  st_nxt.regs.pll_cfg = fr[7:0];
                end else if (fr[14:8] == csp_pkg::OFS_CLKOUT) begin
                  st_nxt.regs.clkout = fr[7:0];
                end else if (fr[14:8] == csp_pkg::OFS_RX_CFG) begin
                  st_nxt.regs.rx_cfg = fr[7:0];
                end else if (fr[14:8] == csp_pkg::OFS_BIAS) begin
                  st_nxt.regs.bias = fr[7:0];
                end
              end
            end
          end
        end
        default: st_nxt.spi_st = csp_pkg::CSP_IDLE;
      endcase
    end

    // ------------------------------------------------------------
    // shared vco divider chain and reference divider
    // ------------------------------------------------------------
    if (vco_rise) begin
      st_nxt.vcnt = st_r.vcnt + 3'd1;
    end
    if (ref_rise) begin
      st_nxt.rcnt = st_r.rcnt + 2'd1;
    end
    // new settings only at the chain wrap: counter taps are low, but the exponent-0 tap is the high vco, so moves to or from 0 can runt [R20]
    if (vco_rise && st_r.vcnt == 3'h7) begin
      nreq = st_r.regs.pll_cfg[csp_pkg::N_LSB+:2];
      if (nreq == 2'd3) begin
        nreq = 2'd2; // [R5]
      end
      st_nxt.act.m   = st_r.regs.pll_cfg[csp_pkg::M_LSB+:2];
      st_nxt.act.n   = nreq;
      st_nxt.act.sel = st_r.regs.pll_cfg[csp_pkg::SEL_BIT];
      st_nxt.act.r   = st_r.regs.clkout[csp_pkg::R_LSB+:2];
    end
    if (ref_rise && st_r.rcnt == 2'h3) begin
      st_nxt.act.l = st_r.regs.clkout[csp_pkg::L_LSB+:2];
      if (st_nxt.act.l == 2'd3) begin
        st_nxt.act.l = 2'd2;
      end
    end
    // feedback tap gives the pll its 2^m multiply [R2]
    st_nxt.fb = div_tap(st_nxt.vcnt, st_r.act.m, vco_s);
    // first output is a tap of the same chain, so phase is fixed [R10] [R11]
    o1 = div_tap(st_nxt.vcnt, st_r.act.r, vco_s);
    // exponent 0 passes the reference; 1 and 2 are counter bits [R12] [R13]
    o2 = div_tap({1'b0, st_nxt.rcnt}, st_r.act.l, ref_s);
    st_nxt.c1 = ~st_r.regs.clkout[csp_pkg::C1_DIS]
              & (o1 ^ st_r.regs.clkout[csp_pkg::C1_INV]); // [R14]
    st_nxt.c2 = ~st_r.regs.clkout[csp_pkg::C2_DIS]
              & (o2 ^ st_r.regs.clkout[csp_pkg::C2_INV]); // [R14]

    // ------------------------------------------------------------
    // duty-cycle restorer: high for half the measured reference period
    // ------------------------------------------------------------
    st_nxt.per_cnt = st_r.per_cnt + DCR_W'(1);
    if (st_r.dcr_cnt != '0) begin
      st_nxt.dcr_cnt = st_r.dcr_cnt - DCR_W'(1);
    end else begin
      st_nxt.dcr_out = 1'b0;
    end
    if (ref_rise) begin
      st_nxt.per_cnt = '0;
      st_nxt.half    = (st_r.per_cnt + DCR_W'(1)) >> 1;
      st_nxt.dcr_cnt = st_r.half;
      st_nxt.dcr_out = 1'b1;
    end
    ref_src = st_r.regs.pll_cfg[csp_pkg::DCR_BIT] ? st_r.dcr_out : ref_s; // [R6]
    // sample clock: buffered reference or vco over 2^n [R4] [R5]
    st_nxt.samp   = st_r.act.sel ? div_tap(st_nxt.vcnt, st_r.act.n, vco_s) : ref_src;
    st_nxt.samp_d = st_r.samp;

    // ------------------------------------------------------------
    // receive pipeline, one stage per sample-clock rising edge [R9]
    // ------------------------------------------------------------
    if (samp_rise) begin
      st_nxt.pipe = {st_r.pipe[csp_pkg::RX_LATENCY-2:0], rx_code_i};
    end

    // mask follows the synchronised pin with no extra qualification [R16] [R18] [R19]
    st_nxt.pd = st_r.pin_sy[1] ? st_r.regs.mask_high : st_r.regs.mask_low;

    // ------------------------------------------------------------
    // synchronous reset: configuration to defaults, clocks keep going
    // ------------------------------------------------------------
    if (!rstn_i) begin
      st_nxt.regs.mask_low  = csp_pkg::RST_MASK_LOW;  // [R17]
      st_nxt.regs.mask_high = csp_pkg::RST_MASK_HIGH; // [R17]
      st_nxt.regs.pll_cfg   = csp_pkg::RST_PLL_CFG;
      st_nxt.regs.clkout    = csp_pkg::RST_CLKOUT;
      st_nxt.regs.rx_cfg    = csp_pkg::RST_RX_CFG;
      st_nxt.regs.bias      = csp_pkg::RST_BIAS;
      st_nxt.act     = '0;
      st_nxt.spi_st  = csp_pkg::CSP_IDLE;
      st_nxt.bits    = 5'd0;
      st_nxt.dout    = 1'b0;
      st_nxt.dout_oe = 1'b0;
      st_nxt.vcnt    = 3'd0;
      st_nxt.rcnt    = 2'd0;
      st_nxt.per_cnt = '0;
      st_nxt.half    = '0;
      st_nxt.dcr_cnt = '0;
      st_nxt.dcr_out = 1'b0;
      st_nxt.pd      = csp_pkg::RST_MASK_LOW;
      // dividers restart, but outputs pass raw clocks meanwhile [R15]
      st_nxt.c1   = vco_s;
      st_nxt.c2   = ref_s;
      st_nxt.fb   = vco_s;
      st_nxt.samp = ref_s;
    end
  end

  always_ff @(posedge core_clk_i) begin
    st_r <= st_nxt;
  end

  assign spi_dout_o                    = st_r.dout;
  assign spi_dout_oe_o                 = st_r.dout_oe;
  assign vco_derived_clock_out_o       = st_r.c1;
  assign reference_derived_clock_out_o = st_r.c2;
  assign sample_clk_o                  = st_r.samp;
  assign receive_word_clock_o          = st_r.samp; // [R1]
  assign pll_feedback_o                = st_r.fb;
  assign pll_mult_o                    = st_r.act.m; // [R2]
  assign adc_low_power_o               = st_r.regs.rx_cfg[csp_pkg::LOWPWR_BIT]; // [R7]
  assign adc_bias_o                    = st_r.regs.bias[csp_pkg::BIAS_MSB:0]; // [R8]
  assign power_down_o                  = st_r.pd;
  assign converter_data_bus_o          = st_r.pipe[csp_pkg::RX_LATENCY-1];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  pwr_sel_a: assert property ($past(rstn_i) |-> power_down_o ==  // [R16]
    ($past(st_r.pin_sy[1]) ? $past(st_r.regs.mask_high) : $past(st_r.regs.mask_low)))
    else $error("power mask does not follow select pin");
  pwr_reset_a: assert property ($rose(rstn_i) |->  // [R17]
    st_r.regs.mask_low == 8'h00 && st_r.regs.mask_high == 8'h7f)
    else $error("power masks wrong after reset");
  low_power_a: assert property ($past(rstn_i) && $changed(adc_low_power_o) |->  // [R7]
    $past(st_r.spi_st) == csp_pkg::CSP_DATA)
    else $error("low power changed without a write");
  bias_code_a: assert property ($past(rstn_i) && $changed(adc_bias_o) |->  // [R8]
    $past(st_r.spi_st) == csp_pkg::CSP_DATA)
    else $error("bias code changed without a write");
  rx_latency_a: assert property ($past(rstn_i) && $changed(converter_data_bus_o) |->  // [R9]
    $past(samp_rise))
    else $error("data bus moved off a sample edge");
  ref_sample_a: assert property ($past(rstn_i) && !$past(st_r.act.sel) &&  // [R4]
    !$past(st_r.regs.pll_cfg[5]) |-> sample_clk_o == $past(ref_s))
    else $error("sample clock is not the reference");
  n_range_a: assert property (st_r.act.n != 2'd3)  // [R5]
    else $error("vco divide exponent out of range");
  c1_dis_a: assert property ($past(rstn_i) && $past(st_r.regs.clkout[0]) |->  // [R14]
    !vco_derived_clock_out_o)
    else $error("first clock output not disabled");
  c2_pass_a: assert property ($past(rstn_i) && $past(st_r.act.l) == 2'd0 &&  // [R12]
    $past(st_r.regs.clkout[5:4]) == 2'b00 |-> reference_derived_clock_out_o == $past(ref_s))
    else $error("second clock output not passing reference");
  mult_hold_a: assert property ($changed(st_r.act.m) |->  // [R20]
    st_r.vcnt == 3'd0 && $past(vco_rise))
    else $error("multiplier changed off the divider wrap");

  pin_high_c: cover property (st_r.pin_sy[1] && power_down_o == st_r.regs.mask_high);
  vco_sel_c: cover property (st_r.act.sel && st_r.act.n == 2'd2 && samp_rise);
  spi_read_c: cover property (spi_dout_oe_o ##1 !spi_dout_oe_o);
  c2_div_c: cover property (st_r.act.l == 2'd2 && $rose(reference_derived_clock_out_o));

endmodule
`default_nettype wire

// file: tb/csp_clk_src.sv
// reference and vco clock source model for the clock synthesizer block
`timescale 1ns/100ps
`default_nettype none
module csp_clk_src #(
  parameter int REF_HALF_NS = 1600
) (
  input  wire logic [1:0] pll_mult_i,
  output logic            ref_clk_o,
  output logic            vco_clk_o
);
  int h;
  // free-running crystal source, period 32 core cycles
  initial begin
    ref_clk_o = 1'b0;
    // offset keeps source edges clear of both core clock edges
    #25;
    forever #(REF_HALF_NS) ref_clk_o = ~ref_clk_o;
  end
  // locked vco at ref times 2^m; m chosen so vco stays slow enough to sample
  initial begin
    vco_clk_o = 1'b0;
    #25;
    forever begin
      h = (^pll_mult_i === 1'bx) ? REF_HALF_NS : (REF_HALF_NS >> pll_mult_i);
      #(h) vco_clk_o = ~vco_clk_o;
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// self-checking testbench for the clock synthesizer and power select block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        core_clk_i, rstn_i, ref_clk, vco_clk, power_select_pin_i;
  logic        spi_clk_i, spi_cs_n_i, spi_din_i, spi_dout_o, spi_dout_oe_o, oe_seen;
  logic [11:0] rx_code_i, converter_data_bus_o;
  logic        c1, c2, smp, wrd, fb, adc_low_power_o;
  logic [1:0]  pll_mult_o;
  logic [2:0]  adc_bias_o;
  logic [7:0]  power_down_o;
  logic [6:0]  sig, prv;
  int          cnt[7], d[7], n_mismatch, compares, cycles;

  csp_clk_src u_csp_clk_src (.pll_mult_i(pll_mult_o), .ref_clk_o(ref_clk), .vco_clk_o(vco_clk));

  csp_top u_csp_top (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .reference_clock_input_i(ref_clk),
    .vco_clk_i(vco_clk), .power_select_pin_i(power_select_pin_i),
    .spi_clk_i(spi_clk_i), .spi_cs_n_i(spi_cs_n_i), .spi_din_i(spi_din_i),
    .rx_code_i(rx_code_i), .spi_dout_o(spi_dout_o), .spi_dout_oe_o(spi_dout_oe_o),
    .vco_derived_clock_out_o(c1), .reference_derived_clock_out_o(c2),
    .sample_clk_o(smp), .receive_word_clock_o(wrd), .pll_feedback_o(fb),
    .pll_mult_o(pll_mult_o), .adc_low_power_o(adc_low_power_o), .adc_bias_o(adc_bias_o),
    .power_down_o(power_down_o), .converter_data_bus_o(converter_data_bus_o)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  // ------------------------------------------------------------
  // rise counters, sampled on the falling edge to stay off the launch edge
  // ------------------------------------------------------------
  assign sig = {fb, wrd, smp, c2, c1, vco_clk, ref_clk};
  initial prv = 7'h00;
  always @(negedge core_clk_i) begin
    for (int k = 0; k < 7; k++) begin
      cnt[k] += int'(sig[k] & ~prv[k]);
    end
    prv <= sig;
  end

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 80000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #10;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk(input int got, input int exp, input int tol);
    compares++;
    if (got > exp + tol || got < exp - tol) begin
      n_mismatch++;
      $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  // ------------------------------------------------------------
  // serial frame: read flag, 7-bit address, 8 data bits, msb first
  // ------------------------------------------------------------
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd,
                      output logic [7:0] rv);
    logic [15:0] f;
    f = {rd, a, wd};
    rv = 8'h00;
    spi_cs_n_i = 1'b0;
    tick(4);
    for (int i = 15; i >= 0; i--) begin
      spi_din_i = f[i];
      tick(5);
      if (i < 8) rv[i] = spi_dout_o;
      if (i == 0) oe_seen = spi_dout_oe_o;
      spi_clk_i = 1'b1;
      tick(5);
      spi_clk_i = 1'b0;
    end
    tick(5);
    spi_cs_n_i = 1'b1;
    tick(4);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    logic [7:0] r;
    xfer(1'b0, a, v, r);
    cmp8({7'h00, oe_seen}, 8'h00);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] r;
    xfer(1'b1, a, 8'h00, r);
    cmp8(r, exp);
    cmp8({6'h00, oe_seen, spi_dout_oe_o}, 8'h02);
  endtask

  task automatic measure(input int w);
    int b[7];
    b = cnt;
    tick(w);
    for (int k = 0; k < 7; k++) d[k] = cnt[k] - b[k];
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_defaults();
    rd_chk(csp_pkg::OFS_MASK_LOW, 8'h00);
    rd_chk(csp_pkg::OFS_MASK_HIGH, 8'h7f);
    rd_chk(csp_pkg::OFS_PLL_CFG, csp_pkg::RST_PLL_CFG);
    rd_chk(csp_pkg::OFS_CLKOUT, csp_pkg::RST_CLKOUT);
    rd_chk(csp_pkg::OFS_RX_CFG, csp_pkg::RST_RX_CFG);
    rd_chk(csp_pkg::OFS_BIAS, 8'h00);
    cmp8(power_down_o, 8'h00);
    power_select_pin_i = 1'b1;
    tick(5);
    cmp8(power_down_o, 8'h7f);
    power_select_pin_i = 1'b0;
    wr(7'h05, 8'hff);
    rd_chk(7'h05, 8'h00);
  endtask

  task automatic t_power();
    wr(csp_pkg::OFS_MASK_LOW, 8'h60);
    wr(csp_pkg::OFS_MASK_HIGH, 8'h85);
    tick(4);
    cmp8(power_down_o, 8'h60);
    power_select_pin_i = 1'b1;
    tick(4);
    cmp8(power_down_o, 8'h85);
    power_select_pin_i = 1'b0;
    tick(4);
    cmp8(power_down_o, 8'h60);
  endtask

  task automatic t_rx_cfg();
    wr(csp_pkg::OFS_RX_CFG, 8'h11);
    wr(csp_pkg::OFS_BIAS, 8'h05);
    tick(2);
    cmp8({7'h00, adc_low_power_o}, 8'h01);
    cmp8({5'h00, adc_bias_o}, 8'h05);
    rd_chk(csp_pkg::OFS_BIAS, 8'h05);
  endtask

  task automatic t_clocks();
    int s0;
    wr(csp_pkg::OFS_PLL_CFG, 8'h23);
    tick(400);
    cmp8({6'h00, pll_mult_o}, 8'h03);
    measure(1024);
    chk(d[1], 8 * d[0], 8);
    chk(d[6], d[0], 1);
    chk(d[4], d[0], 1);
    chk(d[5], d[4], 0);
    for (int n = 0; n < 3; n++) begin
      wr(csp_pkg::OFS_PLL_CFG, 8'h13 | 8'(n << 2));
      tick(100);
      measure(1024);
      chk(d[4], d[1] >> n, 2);
    end
    for (int r = 0; r < 4; r++) begin
      wr(csp_pkg::OFS_CLKOUT, 8'(r << 2));
      tick(100);
      measure(1024);
      chk(d[2], d[1] >> r, 2);
    end
    for (int l = 0; l < 3; l++) begin
      wr(csp_pkg::OFS_CLKOUT, 8'(l << 6));
      tick(200);
      measure(1024);
      chk(d[3], d[0] >> l, 1);
    end
    wr(csp_pkg::OFS_CLKOUT, 8'h22);
    tick(200);
    measure(512);
    chk(d[2], d[1], 2);
    chk(d[3], d[0], 1);
    s0 = cnt[0];
    while (cnt[0] == s0) tick(1);
    tick(8);
    cmp8({7'h00, c2}, 8'h00);
    wr(csp_pkg::OFS_CLKOUT, 8'h11);
    measure(512);
    chk(d[2] + d[3], 0, 0);
  endtask

  task automatic t_latency();
    int s0;
    int k;
    wr(csp_pkg::OFS_PLL_CFG, 8'h1b);
    rx_code_i = 12'h000;
    tick(400);
    s0 = cnt[4];
    while (cnt[4] == s0) tick(1);
    rx_code_i = 12'ha5c;
    s0 = cnt[4];
    k = 0;
    while (converter_data_bus_o !== 12'ha5c && k < 500) begin
      tick(1);
      k++;
    end
    chk(cnt[4] - s0, 10, 0);
  endtask

  task automatic t_reset_run();
    rstn_i = 1'b0;
    measure(256);
    chk(int'(d[2] > 0) + int'(d[3] > 0), 2, 0);
    rstn_i = 1'b1;
    tick(2);
    rd_chk(csp_pkg::OFS_MASK_LOW, 8'h00);
  endtask

  initial begin
    rstn_i = 1'b0;
    power_select_pin_i = 1'b0;
    spi_clk_i = 1'b0;
    spi_cs_n_i = 1'b1;
    spi_din_i = 1'b0;
    rx_code_i = 12'h000;
    tick(20);
    rstn_i = 1'b1;
    tick(2);
    t_defaults();
    t_power();
    t_rx_cfg();
    t_clocks();
    t_latency();
    t_reset_run();
    end_of_test();
  end
endmodule
`default_nettype wire
